// ===== hdl/t2cc_cfg.svh
// Register offsets, field positions, reset values and counts for the timer 2 capture block
`ifndef T2CC_CFG_SVH
`define T2CC_CFG_SVH

// Register offsets on the 8-bit register port
`define T2CC_ADDR_CAPTURE_ENABLE_REG 8'hC1
`define T2CC_ADDR_TIMER_TWO_CONTROL 8'hC8
`define T2CC_ADDR_UNIT4_COMPARE_CAPTURE_ENABLE 8'hC9
`define T2CC_ADDR_CAP_BASE 8'hD0
`define T2CC_ADDR_CAP_LAST 8'hD9

// Field positions in the timer 2 control register (only edge selects live here)
`define T2CC_TIMER_TWO_CONTROL_RELOAD_EDGE 6
`define T2CC_TIMER_TWO_CONTROL_UNIT4_EDGE 5

// Field positions in the unit 4 enable register
`define T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_FUNC_LO 0
`define T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_FUNC_HI 1
`define T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_COMPARE_MODE 2
`define T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_P5EN_LOW 3
`define T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_COUNT_LSB 4
`define T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_COUNT_MSB 6
`define T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_P5EN_HIGH 7

// Reset values
`define T2CC_RST_CAPTURE_ENABLE_REG 8'h00
`define T2CC_RST_UNIT4_COMPARE_CAPTURE_ENABLE 8'h00
`define T2CC_RST_EDGE 2'h0
`define T2CC_RST_PIN_LEVEL 5'h1F
`define T2CC_RST_CAPTURE 16'h0000

// Counts
`define T2CC_UNITS 5
`define T2CC_P5_LINES 8

`endif

// ===== hdl/t2cc_pkg.sv
// Types shared by the timer 2 capture / concurrent compare block
package t2cc_pkg;

  // Two-bit function select of each compare/capture unit
  typedef enum logic [1:0] {
    T2CC_FN_OFF = 2'b00,
    T2CC_FN_CAP_PIN = 2'b01,
    T2CC_FN_COMPARE = 2'b10,
    T2CC_FN_CAP_WRITE = 2'b11
  } t2cc_func_t;

  // Compare outputs of unit 4 toward P1.4 and port 5
  typedef struct packed {
    logic p14_level;
    logic p14_cmp_en;
    logic [7:0] p5_level;
    logic [7:0] p5_cmp_en;
  } t2cc_cmp_out_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t2cc_req_t;

endpackage

// ===== hdl/t2cc_capture_store.sv
// Five 16-bit capture/compare registers with byte writes, capture loads and registered read
`timescale 1ns/1ps
`include "t2cc_cfg.svh"
module t2cc_capture_store #(
  parameter int UNITS = `T2CC_UNITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic [2:0] i_wr_idx,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  input wire logic [UNITS-1:0] i_cap_load,
  input wire logic [15:0] i_cap_value,
  input wire logic i_rd_en,
  input wire logic [2:0] i_rd_idx,
  input wire logic i_rd_hi,
  output logic [7:0] o_rdata,
  output logic [15:0] o_unit4_value
);

  logic [15:0] mem_q [UNITS];

  // Entry index is three bits wide, so at most eight units fit
  if (UNITS < 1 || UNITS > 8) begin : g_bad_units
    $error("t2cc_capture_store: UNITS must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One entry per unit; a capture load beats a byte write in the same cycle
  for (genvar k = 0; k < UNITS; k++) begin : g_entry
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        mem_q[k] <= `T2CC_RST_CAPTURE;
      end else if (i_ce) begin
        if (i_cap_load[k]) begin
          mem_q[k] <= i_cap_value;
        end else if (i_wr_en && i_wr_idx == 3'(k)) begin
          if (i_wr_hi) begin
            mem_q[k][15:8] <= i_wdata;
          end else begin
            mem_q[k][7:0] <= i_wdata;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data from a register; each byte is read on its own access, so the two bytes of one entry can come from different samples
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce && i_rd_en) begin
      if (i_rd_idx < 3'(UNITS)) begin
        o_rdata <= i_rd_hi ? mem_q[i_rd_idx][15:8] : mem_q[i_rd_idx][7:0];
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  assign o_unit4_value = mem_q[UNITS-1];

endmodule

// ===== hdl/t2cc_top.sv
// Timer 2 capture logic for five units and concurrent compare of unit 4
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "t2cc_cfg.svh"
module t2cc_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [15:0] i_timer_count,
  input wire logic i_timer_ovf,
  input wire logic [4:0] i_cap_pin,
  input wire logic i_p14_latch,
  input wire logic [7:0] i_p5_latch,
  output t2cc_pkg::t2cc_cmp_out_t o_cmp,
  output logic [4:0] o_ext_req_set
);

  localparam int UNITS = `T2CC_UNITS;
  localparam int P5N = `T2CC_P5_LINES;

  t2cc_pkg::t2cc_req_t req;
  t2cc_pkg::t2cc_func_t func [UNITS];

  logic [7:0] capture_enable_reg_q;
  logic [7:0] unit4_compare_capture_enable_q;
  logic [7:0] unit4_compare_capture_enable_d;
  logic [1:0] edge_sel_q;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] samp_q;
  logic [4:0] prev_q;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [4:0] edge_hit;
  logic [4:0] recog;
  logic [4:0] pin_pend_q;
  logic [4:0] sw_pend_q;
  logic [4:0] low_wr;
  logic [4:0] cap_load;
  logic cap_window;
  logic [2:0] cap_idx;
  logic cap_hi;
  logic [7:0] cap_off;
  logic [15:0] unit4_value;
  logic [7:0] mem_rdata;
  logic [7:0] ctrl_rdata_q;
  logic rd_mem_q;
  logic match;
  logic match_q;
  logic hit;
  logic compare_mode1;
  logic concurrent;
  logic [2:0] out_count;
  logic p14_q;
  logic [7:0] p5_q;
  logic [7:0] p5_en;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode of the capture byte window: unit k low at base+2k, high at base+2k+1
  assign cap_window = (req.addr >= `T2CC_ADDR_CAP_BASE) && (req.addr <= `T2CC_ADDR_CAP_LAST);
  assign cap_off = req.addr - `T2CC_ADDR_CAP_BASE;
  assign cap_idx = cap_off[3:1];
  assign cap_hi = cap_off[0];

  // One strobe per unit for a software write to its low byte
  for (genvar k = 0; k < UNITS; k++) begin : g_low_wr
    assign low_wr[k] = req.wr && cap_window && !cap_hi && cap_idx == 3'(k);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Function select per unit: units 0-3 from the shared enable register, unit 4 from its own
  for (genvar k = 0; k < UNITS - 1; k++) begin : g_func
    assign func[k] = t2cc_pkg::t2cc_func_t'(capture_enable_reg_q[2*k+1 -: 2]);
  end
  assign func[UNITS-1] = t2cc_pkg::t2cc_func_t'(unit4_compare_capture_enable_q[`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_FUNC_HI:`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_FUNC_LO]);

  ////////////////////////////////////////////////////////////////////////////////
  // Shared capture enable register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      capture_enable_reg_q <= `T2CC_RST_CAPTURE_ENABLE_REG;
    end else if (i_ce && req.wr && req.addr == `T2CC_ADDR_CAPTURE_ENABLE_REG) begin
      capture_enable_reg_q <= req.wdata;
    end
  end

  // Edge selects held here; the other control bits belong to the timer itself
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      edge_sel_q <= `T2CC_RST_EDGE;
    end else if (i_ce && req.wr && req.addr == `T2CC_ADDR_TIMER_TWO_CONTROL) begin
      edge_sel_q <= {req.wdata[`T2CC_TIMER_TWO_CONTROL_UNIT4_EDGE], req.wdata[`T2CC_TIMER_TWO_CONTROL_RELOAD_EDGE]};
    end
  end

  // Unit 4 enable register; a one in the low port-5 enable also sets the compare mode bit
  always_comb begin
    unit4_compare_capture_enable_d = req.wdata;
    if (req.wdata[`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_P5EN_LOW]) begin
      unit4_compare_capture_enable_d[`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_COMPARE_MODE] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      unit4_compare_capture_enable_q <= `T2CC_RST_UNIT4_COMPARE_CAPTURE_ENABLE;
    end else if (i_ce && req.wr && req.addr == `T2CC_ADDR_UNIT4_COMPARE_CAPTURE_ENABLE) begin
      unit4_compare_capture_enable_q <= unit4_compare_capture_enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; the first stage feeds only the second
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_q <= `T2CC_RST_PIN_LEVEL;
      sync2_q <= `T2CC_RST_PIN_LEVEL;
    end else if (i_ce) begin
      sync1_q <= i_cap_pin;
      sync2_q <= sync1_q;
    end
  end

  // One sample per machine cycle and the one before it; idle-high reset avoids a false edge
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      samp_q <= `T2CC_RST_PIN_LEVEL;
      prev_q <= `T2CC_RST_PIN_LEVEL;
    end else if (i_ce) begin
      samp_q <= sync2_q;
      prev_q <= samp_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transition recognition: two successive samples that differ
  assign rise = samp_q & ~prev_q;
  assign fall = ~samp_q & prev_q;

  // Units one to three react to rising edges only; reload and unit 4 follow their selects
  always_comb begin
    edge_hit = rise;
    edge_hit[0] = edge_sel_q[0] ? rise[0] : fall[0];
    edge_hit[4] = edge_sel_q[1] ? rise[4] : fall[4];
  end

  // Pin edges count only in pin capture mode; port latch must hold one for the pin to read
  for (genvar k = 0; k < UNITS; k++) begin : g_recog
    assign recog[k] = edge_hit[k] && func[k] == t2cc_pkg::T2CC_FN_CAP_PIN;
  end

  // Request flags two to six set for one machine cycle, only from pin captures
  assign o_ext_req_set = i_ce ? recog : 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Captures are one machine cycle late: pin recognition and low-byte writes both wait a cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_pend_q <= 5'h00;
    end else if (i_ce) begin
      pin_pend_q <= recog;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sw_pend_q <= 5'h00;
    end else if (i_ce) begin
      for (int k = 0; k < UNITS; k++) begin
        sw_pend_q[k] <= low_wr[k] && func[k] == t2cc_pkg::T2CC_FN_CAP_WRITE;
      end
    end
  end

  // The written byte itself is overwritten by the capture that follows it
  assign cap_load = pin_pend_q | sw_pend_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Capture register store with registered read port
  t2cc_capture_store #(
    .UNITS(UNITS)
  ) u_store (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_wr_en(req.wr && cap_window),
    .i_wr_idx(cap_idx),
    .i_wr_hi(cap_hi),
    .i_wdata(req.wdata),
    .i_cap_load(cap_load),
    .i_cap_value(i_timer_count),
    .i_rd_en(req.rd && cap_window),
    .i_rd_idx(cap_idx),
    .i_rd_hi(cap_hi),
    .o_rdata(mem_rdata),
    .o_unit4_value(unit4_value)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control register read path; unmapped addresses read zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_rdata_q <= 8'h00;
      rd_mem_q <= 1'b0;
    end else if (i_ce && req.rd) begin
      rd_mem_q <= cap_window;
      case (req.addr)
        `T2CC_ADDR_CAPTURE_ENABLE_REG: begin
          ctrl_rdata_q <= capture_enable_reg_q;
        end
        `T2CC_ADDR_UNIT4_COMPARE_CAPTURE_ENABLE: begin
          ctrl_rdata_q <= unit4_compare_capture_enable_q;
        end
        `T2CC_ADDR_TIMER_TWO_CONTROL: begin
          ctrl_rdata_q <= 8'h00;
          ctrl_rdata_q[`T2CC_TIMER_TWO_CONTROL_RELOAD_EDGE] <= edge_sel_q[0];
          ctrl_rdata_q[`T2CC_TIMER_TWO_CONTROL_UNIT4_EDGE] <= edge_sel_q[1];
        end
        default: begin
          ctrl_rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // Both sources are registers; the select was taken with them
  assign o_rdata = rd_mem_q ? mem_rdata : ctrl_rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Unit 4 compare against timer 2; a match counts once, at the cycle the count arrives
  assign compare_mode1 = unit4_compare_capture_enable_q[`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_COMPARE_MODE];
  assign match = func[UNITS-1] == t2cc_pkg::T2CC_FN_COMPARE && i_timer_count == unit4_value;
  assign hit = match && !match_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      match_q <= 1'b0;
    end else if (i_ce) begin
      match_q <= match;
    end
  end

  // P1.4 output: mode 1 copies the shadow latch on a match, mode 0 sets on match, clears on overflow
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      p14_q <= 1'b0;
    end else if (i_ce) begin
      if (hit) begin
        p14_q <= compare_mode1 ? i_p14_latch : 1'b1;
      end else if (i_timer_ovf && !compare_mode1) begin
        p14_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Concurrent compare: low enable set, high enable clear, unit 4 in compare
  assign concurrent = func[UNITS-1] == t2cc_pkg::T2CC_FN_COMPARE && unit4_compare_capture_enable_q[`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_P5EN_LOW]
                      && !unit4_compare_capture_enable_q[`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_P5EN_HIGH];
  assign out_count = unit4_compare_capture_enable_q[`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_COUNT_MSB:`T2CC_UNIT4_COMPARE_CAPTURE_ENABLE_COUNT_LSB];

  // Each enabled port 5 line (0 up to the count field) takes its preloaded level on the same match as P1.4
  for (genvar i = 0; i < P5N; i++) begin : g_p5
    assign p5_en[i] = concurrent && out_count >= 3'(i);
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        p5_q[i] <= 1'b0;
      end else if (i_ce && hit && p5_en[i]) begin
        p5_q[i] <= i_p5_latch[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs toward the port pins; P1.4 stays the unit 4 output whatever port 5 does
  assign o_cmp.p14_level = p14_q;
  assign o_cmp.p14_cmp_en = func[UNITS-1] == t2cc_pkg::T2CC_FN_COMPARE;
  assign o_cmp.p5_level = p5_q;
  assign o_cmp.p5_cmp_en = p5_en;

endmodule

// ===== bench/t2cc_pins_model.sv
// External capture pins and port latch pattern facing the capture block
`timescale 1ns/1ps
module t2cc_pins_model (
  input wire logic [4:0] i_lvl,
  input wire logic [8:0] i_pat,
  output logic [4:0] o_cap_pin,
  output logic o_p14_latch,
  output logic [7:0] o_p5_latch
);
  ////////////////////////////////////////////////////////////////////////////////
  // Latches hold one, so each pin only shows the external level; idle is high
  assign o_cap_pin = i_lvl;
  // Next pattern is parked in the latches well before the match count
  assign o_p14_latch = i_pat[8];
  assign o_p5_latch = i_pat[7:0];
endmodule

// ===== bench/t2cc_assertions.sv
// Port-level checks of the capture block, bound into its top module
`timescale 1ns/1ps
module t2cc_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [15:0] i_timer_count,
  input wire logic [4:0] i_cap_pin,
  input wire logic i_p14_latch,
  input wire logic [7:0] i_p5_latch,
  input wire t2cc_pkg::t2cc_cmp_out_t o_cmp,
  input wire logic [4:0] o_ext_req_set
);
  logic [7:0] cc4_q;
  logic [1:0] sel_q;
  logic [15:0] v4_q;
  logic hit;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Shadow of control writes; capture loads of unit 4 are not mirrored
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cc4_q <= 8'h00;
      sel_q <= 2'h0;
      v4_q <= 16'h0000;
    end else if (i_ce && i_wr) begin
      if (i_addr == 8'hC9) cc4_q <= i_wdata | {5'h00, i_wdata[3], 2'h0};
      if (i_addr == 8'hC8) sel_q <= {i_wdata[6], i_wdata[5]};
      if (i_addr == 8'hD8) v4_q[7:0] <= i_wdata;
      if (i_addr == 8'hD9) v4_q[15:8] <= i_wdata;
    end
  end
  // Unit 4 in compare function meets its count
  assign hit = cc4_q[1:0] == 2'h2 && i_timer_count == v4_q;
  ////////////////////////////////////////////////////////////////////////////////
  a_rise_only: assert property (o_ext_req_set[3:1] != 3'h0 |->
    (o_ext_req_set[3:1] & ~($past(i_cap_pin[3:1], 3) & ~$past(i_cap_pin[3:1], 4))) == 3'h0)
    else $error("request from units one to three without rising edge");
  a_reload_edge: assert property (o_ext_req_set[0] |->
    $past(i_cap_pin[0], 3) == sel_q[1] && $past(i_cap_pin[0], 4) != sel_q[1])
    else $error("reload request on wrong edge");
  a_unit4_edge: assert property (o_ext_req_set[4] |->
    $past(i_cap_pin[4], 3) == sel_q[0] && $past(i_cap_pin[4], 4) != sel_q[0])
    else $error("unit four request on wrong edge");
  a_req_single: assert property (o_ext_req_set != 5'h00 |=> o_ext_req_set == 5'h00)
    else $error("request pulse longer than one cycle");
  a_unit4_compare_capture_enable_read: assert property (i_ce && i_rd && i_addr == 8'hC9 |=> o_rdata == cc4_q)
    else $error("unit four enable readback wrong");
  a_p5_count: assert property (o_cmp.p5_cmp_en ==
    ((cc4_q[1:0] == 2'h2 && cc4_q[3] && !cc4_q[7]) ? (8'hFF >> (3'h7 - cc4_q[6:4])) : 8'h00))
    else $error("port 5 enables do not follow count field");
  a_p14_enable: assert property (o_cmp.p14_cmp_en == (cc4_q[1:0] == 2'h2))
    else $error("P1.4 compare enable wrong");
  a_p14_match: assert property (hit && $past(i_timer_count) != v4_q |=>
    o_cmp.p14_level == (cc4_q[2] ? $past(i_p14_latch) : 1'b1))
    else $error("P1.4 level wrong after match");
  a_p5_pattern: assert property (hit && cc4_q[3] && $past(i_timer_count) != v4_q |=>
    (o_cmp.p5_level & o_cmp.p5_cmp_en) == ($past(i_p5_latch) & o_cmp.p5_cmp_en))
    else $error("port 5 pattern wrong after match");
  c_pin_req: cover property (o_ext_req_set != 5'h00);
  c_cmp_hit: cover property (hit && cc4_q[3]);
  c_wr_cap: cover property (i_wr && i_addr == 8'hD8 && cc4_q[1:0] == 2'h3);
endmodule
bind t2cc_top t2cc_chk t2cc_chk_inst (.i_sys_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_timer_count, .i_cap_pin, .i_p14_latch, .i_p5_latch, .o_cmp, .o_ext_req_set);

// ===== bench/t2cc_top_tb.sv
// Self-checking bench for the timer 2 capture and concurrent compare block
`timescale 1ns/1ps
module t2cc_top_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [15:0] i_timer_count = 16'h12F0;
  logic i_timer_ovf;
  logic [4:0] i_cap_pin;
  logic i_p14_latch;
  logic [7:0] i_p5_latch;
  t2cc_pkg::t2cc_cmp_out_t o_cmp;
  logic [4:0] o_ext_req_set;
  logic [4:0] lvl = 5'h1F;
  logic [8:0] pat = 9'h000;
  logic [15:0] cap_e [5] = '{default: 16'h0000};
  logic [15:0] tw;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  t2cc_pins_model t2cc_pins_model_inst (.i_lvl(lvl), .i_pat(pat), .o_cap_pin(i_cap_pin),
    .o_p14_latch(i_p14_latch), .o_p5_latch(i_p5_latch));
  t2cc_top t2cc_top_inst (.i_sys_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_timer_count, .i_timer_ovf, .i_cap_pin, .i_p14_latch, .i_p5_latch, .o_cmp, .o_ext_req_set);
  // Clock of 100 ns
  always #50 i_sys_clk = ~i_sys_clk;
  // Timer starts off a byte boundary so captures cross into the high byte
  always @(posedge i_sys_clk) i_timer_count <= i_rst ? 16'h12F0 : i_timer_count + 16'h0001;
  assign i_timer_ovf = i_timer_count == 16'hFFFF;
  // Hang guard, far beyond the few hundred cycles the tests need
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Write; tw is the count the next edge samples, for write captures
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    tw = i_timer_count + 16'h0001;
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
    d = o_rdata;
  endtask
  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk("register", {8'h00, e}, {8'h00, d});
  endtask
  task automatic rdcap(input int k, output logic [15:0] v);
    rd(8'hD0 + 8'(2 * k), v[7:0]);
    rd(8'hD1 + 8'(2 * k), v[15:8]);
  endtask
  // Move one pin, watch for the request, then read the unit back
  task automatic pin_edge(input int k, input logic v, input logic e);
    logic [4:0] seen;
    logic [15:0] t;
    logic [15:0] r;
    int n;
    seen = 5'h00;
    n = 0;
    lvl[k] <= v;
    repeat (8) begin
      @(posedge i_sys_clk);
      if (seen === 5'h00) begin
        n++;
        seen = o_ext_req_set;
        t = i_timer_count;
      end
    end
    chk("request", 16'(e ? 5'h01 << k : 5'h00), 16'(seen));
    if (e) begin
      chk("latency", 16'h0004, 16'(n));
      cap_e[k] = t + 16'h0001; // Load takes the count of the cycle after the request
    end
    rdcap(k, r);
    chk("pin capture", cap_e[k], r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] r;
    logic [15:0] tgt;
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    chkrd(8'hC9, 8'h00);
    chkrd(8'hC1, 8'h00);
    chkrd(8'h80, 8'h00);
    // Clock enable low: a write must not land
    i_ce <= 1'b0;
    wr(8'hC1, 8'hAA);
    i_ce <= 1'b1;
    chkrd(8'hC1, 8'h00);
    pin_edge(1, 1'b0, 1'b0);
    // Pin function everywhere, edge selects clear, then set
    wr(8'hC1, 8'h55);
    wr(8'hC9, 8'h01);
    for (int k = 0; k < 5; k++) begin
      pin_edge(k, 1'b0, k == 0 || k == 4);
      pin_edge(k, 1'b1, k != 0 && k != 4);
    end
    wr(8'hC8, 8'h60);
    for (int k = 0; k < 5; k += 4) begin
      pin_edge(k, 1'b0, 1'b0);
      pin_edge(k, 1'b1, 1'b1);
    end
    // Write-triggered capture: the written byte must not survive
    wr(8'hC1, 8'hFF);
    wr(8'hC9, 8'h03);
    for (int k = 0; k < 5; k++) begin
      wr(8'hD0 + 8'(2 * k), 8'h5A);
      cap_e[k] = tw;
      rdcap(k, r);
      chk("write capture", cap_e[k], r);
      chk("request", 16'h0000, 16'(o_ext_req_set));
    end
    // Pin and write modes side by side
    wr(8'hC1, 8'h77);
    pin_edge(1, 1'b0, 1'b0);
    pin_edge(1, 1'b1, 1'b1);
    wr(8'hD0, 8'h00);
    rdcap(0, r);
    chk("mixed capture", tw, r);
    // A read in the same cycle as the capture load sees the byte from before the load
    i_wr <= 1'b1;
    i_addr <= 8'hD0;
    i_wdata <= 8'h00;
    @(posedge i_sys_clk);
    tw = i_timer_count + 16'h0001;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
    chk("read during capture", 16'h0000, {8'h00, o_rdata});
    rdcap(0, r);
    chk("capture after read", tw, r);
    // Every output count with the mode bit written as zero
    for (int n = 0; n < 8; n++) begin
      wr(8'hC9, {1'b0, 3'(n), 4'hA});
      chkrd(8'hC9, {1'b0, 3'(n), 4'hE});
      chk("p5 enable", 16'(8'hFF >> (7 - n)), 16'(o_cmp.p5_cmp_en));
      chk("p14 enable", 16'h0001, 16'(o_cmp.p14_cmp_en));
    end
    // Low byte first, so no stale half can match; a low P1.4 shadow tells mode 1 from mode 0
    pat <= 9'h0A5;
    tgt = i_timer_count + 16'h0040;
    wr(8'hD8, tgt[7:0]);
    wr(8'hD9, tgt[15:8]);
    for (int w = 0; w < 200 && o_cmp.p5_level === 8'h00; w++) @(posedge i_sys_clk);
    chk("match time", tgt + 16'h0001, i_timer_count);
    chk("p5 pattern", 16'h00A5, 16'(o_cmp.p5_level));
    chk("p14 level", 16'h0000, 16'(o_cmp.p14_level));
    // Compare mode 0 without port 5: the match sets P1.4
    wr(8'hC9, 8'h02);
    chkrd(8'hC9, 8'h02);
    tgt = i_timer_count + 16'h0040;
    wr(8'hD8, tgt[7:0]);
    wr(8'hD9, tgt[15:8]);
    chk("p5 enable", 16'h0000, 16'(o_cmp.p5_cmp_en));
    for (int w = 0; w < 200 && o_cmp.p14_level !== 1'b1; w++) @(posedge i_sys_clk);
    chk("mode 0 match time", tgt + 16'h0001, i_timer_count);
    chk("p5 held", 16'h00A5, 16'(o_cmp.p5_level));
    end_sim();
  end
endmodule
